//--- verilog/cwd_decoder.sv
// Configuration word option decoder with register port and pin-remap lock.
`timescale 1ns/100ps
module cwd_decoder
  import cwd_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_LONG_CYC  = CWD_POWERUP_DELAY_TIMER_LONG_CYC,
  parameter int POWERUP_DELAY_TIMER_MID_CYC   = CWD_POWERUP_DELAY_TIMER_MID_CYC,
  parameter int POWERUP_DELAY_TIMER_SHORT_CYC = CWD_POWERUP_DELAY_TIMER_SHORT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Device inputs
  input  wire logic        lvp_enable_i,
  input  wire logic        stack_overflow_i,
  input  wire logic        stack_underflow_i,
  input  wire logic        instr_clock_i,
  input  wire logic        port_clock_pin_i,
  // Decoded options
  output logic             analog_range_select_o,
  output logic             clock_output_pin_o,
  output logic [1:0]       current_oscillator_select_o,
  output logic             external_clock_high_range_o,
  output logic             external_clock_low_range_o,
  output logic             external_oscillator_enable_o,
  output logic             debugger_enable_o,
  output logic             stack_fault_reset_o,
  output logic             pin_remap_locked_o,
  output logic             brownout_level_high_o,
  output logic             brownout_active_o,
  output logic             watchdog_active_o,
  output logic             powerup_done_o,
  output logic             external_reset_pin_is_reset_o
);
  typedef struct packed {
    logic [15:0] word1;
    logic [15:0] word2;
    logic        loaded;
    logic        unlocked;
    logic        locked;
    logic        lock_used;
    logic        sw_bor;
    logic        sw_wdt;
    logic        sleep;
    logic        ovf;
    logic        unf;
    logic [15:0] rdata;
    logic        analog;
    logic        clkpin;
    logic [1:0]  current_oscillator_select;
    logic        external_clock_high_range;
    logic        external_clock_low_range;
    logic        exten;
    logic        dbg;
    logic        fault_rst;
    logic        brownout_level_select;
    logic        bor_act;
    logic        wdt_act;
    logic        external_reset_pin;
    logic        powerup_delay_timer_go;
    logic [1:0]  in_sync1;
    logic [1:0]  in_sync2;
  } cwd_state_t;

  cwd_state_t st_reg;
  cwd_state_t st_next;
  logic       powerup_delay_timer_done;
  // The stored words stand for the nonvolatile array, so device reset must leave them alone.
  logic [15:0] live1_reg = CWD_RST_CLOCK_WORD;
  logic [15:0] live2_reg = CWD_RST_RESET_WORD;

  always_ff @(posedge clk_i) begin
    if (wr_i && addr_i == CWD_OFS_CLOCK_WORD) begin
      live1_reg <= wdata_i;
    end
    if (wr_i && addr_i == CWD_OFS_RESET_WORD) begin
      live2_reg <= wdata_i;
    end
  end

  // Four-way mode decode shared by brown-out and watchdog.
  function automatic logic mode_active(input logic [1:0] m, input logic sw, input logic slp);
    unique case (m)
      2'h3: mode_active = 1'b1;
      2'h2: mode_active = !slp;
      2'h1: mode_active = sw;
      2'h0: mode_active = 1'b0;
    endcase
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.powerup_delay_timer_go = 1'b0;
    st_next.rdata = 16'h0;
    // Stack inputs come from the core but are synchronised anyway for safety.
    st_next.in_sync1 = {stack_overflow_i, stack_underflow_i};
    st_next.in_sync2 = st_reg.in_sync1;
    // Latch the stored words once after reset; later writes wait for the next reset.
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      st_next.powerup_delay_timer_go = 1'b1;
      st_next.word1 = live1_reg;
      st_next.word2 = live2_reg;
    end
    if (wr_i) begin
      unique case (addr_i)
        CWD_OFS_CONTROL: begin
          st_next.sw_bor = wdata_i[CWD_CT_SWBOR];
          st_next.sw_wdt = wdata_i[CWD_CT_SWWDT];
          st_next.sleep = wdata_i[CWD_CT_SLEEP];
          st_next.unlocked = wdata_i[CWD_CT_UNLOCK];
          if (st_reg.unlocked && wdata_i[CWD_CT_LOCKSET] &&
              !(st_reg.word2[CWD_B2_ONEWAY] && st_reg.lock_used)) begin
            st_next.locked = 1'b1;
            st_next.lock_used = 1'b1;
            st_next.unlocked = 1'b0;
          end else if (st_reg.unlocked && wdata_i[CWD_CT_LOCKCLR] &&
                       !st_reg.word2[CWD_B2_ONEWAY]) begin
            st_next.locked = 1'b0;
            st_next.unlocked = 1'b0;
          end
          if (wdata_i[CWD_CT_CLRFLAGS]) begin
            st_next.ovf = 1'b0;
            st_next.unf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle.
    if (st_reg.in_sync2[1]) st_next.ovf = 1'b1;
    if (st_reg.in_sync2[0]) st_next.unf = 1'b1;
    if (rd_i) begin
      unique case (addr_i)
        CWD_OFS_CLOCK_WORD: st_next.rdata = live1_reg;
        CWD_OFS_RESET_WORD: st_next.rdata = live2_reg;
        CWD_OFS_STATUS: st_next.rdata = {12'h0, powerup_delay_timer_done, st_reg.locked,
                                         st_reg.unf, st_reg.ovf};
        default: st_next.rdata = 16'h0;
      endcase
    end
    st_next.analog = st_reg.word1[CWD_B1_ANALOG];
    st_next.clkpin = st_reg.word1[CWD_B1_CLOCK_OUTPUT_PIN_N] ? port_clock_pin_i
                                                   : instr_clock_i;
    st_next.current_oscillator_select = st_reg.word1[CWD_B1_RESET_OSCILLATOR_SELECT +: 2];
    st_next.external_clock_high_range = st_reg.word1[CWD_B1_EXTERNAL_OSCILLATOR +: 2] == 2'h3;
    st_next.external_clock_low_range = st_reg.word1[CWD_B1_EXTERNAL_OSCILLATOR +: 2] == 2'h2;
    st_next.exten = st_reg.word1[CWD_B1_RESET_OSCILLATOR_SELECT +: 2] == 2'h3 &&
                    st_reg.word1[CWD_B1_EXTERNAL_OSCILLATOR + 1] == 1'b1;
    st_next.dbg = !st_reg.word2[CWD_B2_DEBUG_N];
    st_next.fault_rst = st_reg.word2[CWD_B2_STACK] &&
                        (st_reg.in_sync2 != 2'h0);
    st_next.brownout_level_select = st_reg.word2[CWD_B2_BROWNOUT_LEVEL_SELECT];
    st_next.bor_act = mode_active(st_reg.word2[CWD_B2_BROWNOUT_ENABLE_MODE +: 2], st_reg.sw_bor,
                                  st_reg.sleep);
    st_next.wdt_act = mode_active(st_reg.word2[CWD_B2_WATCHDOG_ENABLE_MODE +: 2], st_reg.sw_wdt,
                                  st_reg.sleep);
    st_next.external_reset_pin = lvp_enable_i || st_reg.word2[CWD_B2_EXT_RESET_PIN_ENABLE];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
      st_reg.word1 <= CWD_RST_CLOCK_WORD;
      st_reg.word2 <= CWD_RST_RESET_WORD;
    end else begin
      st_reg <= st_next;
    end
  end

  // Delay counter; a 3 selection finishes one cycle after start.
  cwd_powerup_delay_timer #(
    .LONG_CYC  (POWERUP_DELAY_TIMER_LONG_CYC),
    .MID_CYC   (POWERUP_DELAY_TIMER_MID_CYC),
    .SHORT_CYC (POWERUP_DELAY_TIMER_SHORT_CYC)
  ) u_powerup_delay_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (st_reg.powerup_delay_timer_go),
    .sel_i   (st_reg.word2[CWD_B2_POWERUP_DELAY_SELECT +: 2]),
    .done_o  (powerup_delay_timer_done)
  );

  assign rdata_o = st_reg.rdata;
  assign analog_range_select_o = st_reg.analog;
  assign clock_output_pin_o = st_reg.clkpin;
  assign current_oscillator_select_o = st_reg.current_oscillator_select;
  assign external_clock_high_range_o = st_reg.external_clock_high_range;
  assign external_clock_low_range_o = st_reg.external_clock_low_range;
  assign external_oscillator_enable_o = st_reg.exten;
  assign debugger_enable_o = st_reg.dbg;
  assign stack_fault_reset_o = st_reg.fault_rst;
  assign pin_remap_locked_o = st_reg.locked;
  assign brownout_level_high_o = st_reg.brownout_level_select;
  assign brownout_active_o = st_reg.bor_act;
  assign watchdog_active_o = st_reg.wdt_act;
  assign powerup_done_o = powerup_delay_timer_done;
  assign external_reset_pin_is_reset_o = st_reg.external_reset_pin;

  // Outputs come out of reset at zero, so some of the checks wait until the latch has run once.
  analog_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded |-> analog_range_select_o == $past(st_reg.word1[CWD_B1_ANALOG]))
    else $error("analog range wrong");
  debug_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    debugger_enable_o == !$past(st_reg.word2[CWD_B2_DEBUG_N]))
    else $error("debugger enable wrong");
  osc_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded |-> current_oscillator_select_o == $past(st_reg.word1[5:4]))
    else $error("oscillator select wrong");
  ext_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(external_clock_high_range_o && external_clock_low_range_o))
    else $error("both clock ranges");
  oneway_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.word2[CWD_B2_ONEWAY] && st_reg.locked |=> st_reg.locked)
    else $error("one-way lock cleared");
  lock_needs_unlock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(st_reg.locked) |-> $past(st_reg.unlocked))
    else $error("lock changed without unlock");
  external_reset_pin_lvp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded && lvp_enable_i |=> external_reset_pin_is_reset_o)
    else $error("reset pin lost under lvp");
  stack_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.in_sync2[1] |=> st_reg.ovf)
    else $error("overflow flag not set");
  stack_rst_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stack_fault_reset_o |-> $past(st_reg.word2[CWD_B2_STACK]))
    else $error("fault reset while disabled");
  bor_always_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded && $past(st_reg.word2[7:6]) == 2'h3 |-> brownout_active_o)
    else $error("brown-out not forced on");
  wdt_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(st_reg.word2[4:3]) == 2'h0 |-> !watchdog_active_o)
    else $error("watchdog not off");
  brownout_level_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded |-> brownout_level_high_o == $past(st_reg.word2[CWD_B2_BROWNOUT_LEVEL_SELECT]))
    else $error("brown-out level wrong");
  clock_output_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(st_reg.word1[CWD_B1_CLOCK_OUTPUT_PIN_N]) |-> clock_output_pin_o == $past(instr_clock_i))
    else $error("clock pin not driven");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.loaded |=> $stable(st_reg.word2))
    else $error("latched word changed");
endmodule // cwd_decoder

//--- verilog/cwd_pkg.sv
// Package with offsets, field positions, reset values and timing counts for the option decoder.
package cwd_pkg;
  localparam logic [15:0] CWD_OFS_CLOCK_WORD = 16'h8007;
  localparam logic [15:0] CWD_OFS_RESET_WORD = 16'h8008;
  localparam logic [15:0] CWD_OFS_STATUS     = 16'h8010;
  localparam logic [15:0] CWD_OFS_CONTROL    = 16'h8011;
  localparam logic [15:0] CWD_RST_CLOCK_WORD = 16'h3fff;
  localparam logic [15:0] CWD_RST_RESET_WORD = 16'h3fff;
  localparam int CWD_B1_ANALOG   = 12;
  localparam int CWD_B1_CLOCK_OUTPUT_PIN_N = 8;
  localparam int CWD_B1_RESET_OSCILLATOR_SELECT   = 4;
  localparam int CWD_B1_EXTERNAL_OSCILLATOR   = 0;
  localparam int CWD_B2_DEBUG_N  = 13;
  localparam int CWD_B2_STACK    = 12;
  localparam int CWD_B2_ONEWAY   = 11;
  localparam int CWD_B2_BROWNOUT_LEVEL_SELECT     = 9;
  localparam int CWD_B2_BROWNOUT_ENABLE_MODE    = 6;
  localparam int CWD_B2_WATCHDOG_ENABLE_MODE     = 3;
  localparam int CWD_B2_POWERUP_DELAY_SELECT    = 1;
  localparam int CWD_B2_EXT_RESET_PIN_ENABLE    = 0;
  localparam int CWD_CT_UNLOCK   = 0;
  localparam int CWD_CT_LOCKSET  = 1;
  localparam int CWD_CT_LOCKCLR  = 2;
  localparam int CWD_CT_SWBOR    = 3;
  localparam int CWD_CT_SWWDT    = 4;
  localparam int CWD_CT_SLEEP    = 5;
  localparam int CWD_CT_CLRFLAGS = 6;
  localparam int CWD_CLK_MHZ     = 50;
  localparam int CWD_POWERUP_DELAY_TIMER_LONG_MS  = 64;
  localparam int CWD_POWERUP_DELAY_TIMER_MID_MS   = 16;
  localparam int CWD_POWERUP_DELAY_TIMER_SHORT_MS = 1;
  localparam int CWD_POWERUP_DELAY_TIMER_LONG_CYC  = CWD_POWERUP_DELAY_TIMER_LONG_MS * 1000 * CWD_CLK_MHZ;
  localparam int CWD_POWERUP_DELAY_TIMER_MID_CYC   = CWD_POWERUP_DELAY_TIMER_MID_MS * 1000 * CWD_CLK_MHZ;
  localparam int CWD_POWERUP_DELAY_TIMER_SHORT_CYC = CWD_POWERUP_DELAY_TIMER_SHORT_MS * 1000 * CWD_CLK_MHZ;
  typedef enum logic [1:0] {CWD_OSC_HF32, CWD_OSC_LF, CWD_OSC_HF1, CWD_OSC_EXT} cwd_osc_t;
endpackage

//--- verilog/cwd_powerup_delay_timer.sv
// Power-up delay counter loaded from the delay selection.
`timescale 1ns/100ps
module cwd_powerup_delay_timer
  import cwd_pkg::*;
#(
  parameter int LONG_CYC  = CWD_POWERUP_DELAY_TIMER_LONG_CYC,
  parameter int MID_CYC   = CWD_POWERUP_DELAY_TIMER_MID_CYC,
  parameter int SHORT_CYC = CWD_POWERUP_DELAY_TIMER_SHORT_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [1:0] sel_i,
  // Status
  output logic            done_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } cwd_powerup_delay_timer_st_t;
  cwd_powerup_delay_timer_st_t st_reg;
  cwd_powerup_delay_timer_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (start_i) begin
      unique case (sel_i)
        2'h3: st_next.cnt = 32'h0;
        2'h2: st_next.cnt = 32'(LONG_CYC);
        2'h1: st_next.cnt = 32'(MID_CYC);
        2'h0: st_next.cnt = 32'(SHORT_CYC);
      endcase
      st_next.done = (sel_i == 2'h3);
    end else if (st_reg.cnt != 32'h0) begin
      st_next.cnt = st_reg.cnt - 32'h1;
      st_next.done = (st_reg.cnt == 32'h1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o = st_reg.done;
endmodule // cwd_powerup_delay_timer

//--- sim/tb_cwd_decoder.sv
// Self-checking testbench for the configuration word option decoder.
`timescale 1ns/100ps
module tb_cwd_decoder;
  import cwd_pkg::*;
  localparam int LONG_C  = 20;
  localparam int MID_C   = 10;
  localparam int SHORT_C = 5;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o;
  logic        lvp_enable_i = 1'b0, stack_overflow_i = 1'b0, stack_underflow_i = 1'b0;
  logic        instr_clock_i = 1'b0, port_clock_pin_i = 1'b0;
  logic        analog_range_select_o, clock_output_pin_o, external_clock_high_range_o;
  logic        external_clock_low_range_o, external_oscillator_enable_o, debugger_enable_o;
  logic        stack_fault_reset_o, pin_remap_locked_o, brownout_level_high_o;
  logic        brownout_active_o, watchdog_active_o, powerup_done_o;
  logic        external_reset_pin_is_reset_o;
  logic [1:0]  current_oscillator_select_o;
  logic [15:0] nv1, nv2, dec1, dec2, rv;
  logic        sleep_m, swbor, swwdt, lockm;
  int          err_count = 0, checked = 0, seed;

  `define CHK(nm, ex, got) begin checked++; if ((ex) !== (got)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

  always #10 clk_i = ~clk_i;

  cwd_decoder #(.POWERUP_DELAY_TIMER_LONG_CYC(LONG_C), .POWERUP_DELAY_TIMER_MID_CYC(MID_C), .POWERUP_DELAY_TIMER_SHORT_CYC(SHORT_C)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .lvp_enable_i(lvp_enable_i),
    .stack_overflow_i(stack_overflow_i), .stack_underflow_i(stack_underflow_i),
    .instr_clock_i(instr_clock_i), .port_clock_pin_i(port_clock_pin_i),
    .analog_range_select_o(analog_range_select_o), .clock_output_pin_o(clock_output_pin_o),
    .current_oscillator_select_o(current_oscillator_select_o),
    .external_clock_high_range_o(external_clock_high_range_o),
    .external_clock_low_range_o(external_clock_low_range_o),
    .external_oscillator_enable_o(external_oscillator_enable_o),
    .debugger_enable_o(debugger_enable_o), .stack_fault_reset_o(stack_fault_reset_o),
    .pin_remap_locked_o(pin_remap_locked_o), .brownout_level_high_o(brownout_level_high_o),
    .brownout_active_o(brownout_active_o), .watchdog_active_o(watchdog_active_o),
    .powerup_done_o(powerup_done_o),
    .external_reset_pin_is_reset_o(external_reset_pin_is_reset_o));

  function automatic logic mode_on(input logic [1:0] m, input logic sw);
    return (m == 2'b11) || (m == 2'b10 && !sleep_m) || (m == 2'b01 && sw);
  endfunction

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic ctl(input logic [15:0] c);
    wr(CWD_OFS_CONTROL, c);
    swbor = c[CWD_CT_SWBOR]; swwdt = c[CWD_CT_SWWDT]; sleep_m = c[CWD_CT_SLEEP];
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic chk_opts();
    `CHK("analog", dec1[12], analog_range_select_o)
    `CHK("osc", dec1[5:4], current_oscillator_select_o)
    `CHK("ech", dec1[1:0] == 2'b11, external_clock_high_range_o)
    `CHK("ecl", dec1[1:0] == 2'b10, external_clock_low_range_o)
    `CHK("external_oscillator", dec1[5:4] == 2'b11 && dec1[1], external_oscillator_enable_o)
    `CHK("debug", ~dec2[13], debugger_enable_o)
    `CHK("brownout_level_select", dec2[9], brownout_level_high_o)
    `CHK("bor", mode_on(dec2[7:6], swbor), brownout_active_o)
    `CHK("wdt", mode_on(dec2[4:3], swwdt), watchdog_active_o)
    `CHK("external_reset_pin", lvp_enable_i | dec2[0], external_reset_pin_is_reset_o)
    `CHK("stkrst", 1'b0, stack_fault_reset_o)
  endtask

  task automatic do_reset();
    int n, e;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    #1 `CHK("rst_done", 1'b0, powerup_done_o)
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    dec1 = nv1; dec2 = nv2; sleep_m = 0; swbor = 0; swwdt = 0; lockm = 0;
    n = 0;
    while (powerup_done_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1 n++;
    end
    e = dec2[2:1] == 2'b11 ? 1 : dec2[2:1] == 2'b10 ? LONG_C : dec2[2:1] == 2'b01 ? MID_C : SHORT_C;
    `CHK("powerup_delay_timer_min", 1'b1, n >= e)
    `CHK("powerup_delay_timer_max", 1'b1, n <= e + 4)
    if (n >= 200) finish_test();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic chk_clkpin();
    logic i0, p0;
    repeat (6) begin
      @(posedge clk_i);
      i0 = 1'($urandom);
      p0 = 1'($urandom);
      instr_clock_i <= i0; port_clock_pin_i <= p0;
      @(posedge clk_i);
      #1 `CHK("clkpin", dec1[8] ? p0 : i0, clock_output_pin_o)
    end
  endtask

  task automatic lock_test();
    ctl(16'h0002);
    `CHK("lock_nounl", 1'b0, pin_remap_locked_o)
    ctl(16'h0001); ctl(16'h0002);
    lockm = 1'b1;
    `CHK("lock_set", 1'b1, pin_remap_locked_o)
    ctl(16'h0001); ctl(16'h0004);
    lockm = dec2[11];
    `CHK("lock_clr", lockm, pin_remap_locked_o)
    rd(CWD_OFS_STATUS, rv);
    `CHK("status", {12'h000, 1'b1, lockm, 2'b00}, rv)
  endtask

  task automatic stack_test();
    int hits;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      stack_overflow_i <= (i == 0); stack_underflow_i <= (i == 1);
      @(posedge clk_i);
      stack_overflow_i <= 1'b0; stack_underflow_i <= 1'b0;
      hits = 0;
      repeat (8) begin
        @(posedge clk_i);
        #1 hits += (stack_fault_reset_o === 1'b1);
      end
      `CHK("stk_pulse", dec2[12], hits > 0)
      rd(CWD_OFS_STATUS, rv);
      `CHK("stk_flag", {12'h000, 1'b1, lockm, i == 1, i == 0}, rv)
      ctl(16'h0040);
      rd(CWD_OFS_STATUS, rv);
      `CHK("stk_clr", {12'h000, 1'b1, lockm, 2'b00}, rv)
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    logic [15:0] w1, w2;
    logic [1:0]  f;
    seed = $urandom(60655);
    nv1 = CWD_RST_CLOCK_WORD;
    nv2 = CWD_RST_RESET_WORD;
    do_reset();
    rd(CWD_OFS_CLOCK_WORD, rv);
    `CHK("word1_rst", CWD_RST_CLOCK_WORD, rv)
    rd(16'h8009, rv);
    `CHK("unmapped", 16'h0000, rv)
    rd(CWD_OFS_CONTROL, rv);
    `CHK("ctl_rd", 16'h0000, rv)
    for (int t = 0; t < 6; t++) begin
      w1 = 16'($urandom);
      w2 = 16'($urandom);
      f = 2'(t);
      if (t < 4) begin
        w1[5:4] = f; w1[1:0] = f; w2[7:6] = f; w2[4:3] = f; w2[2:1] = f;
        w2[13] = 1'b1;
        w2[9] = 1'b0;
      end
      wr(CWD_OFS_CLOCK_WORD, w1);
      wr(CWD_OFS_RESET_WORD, w2);
      wr(16'h8009, 16'hffff);
      nv1 = w1; nv2 = w2;
      repeat (2) @(posedge clk_i);
      #1 chk_opts();
      rd(CWD_OFS_CLOCK_WORD, rv);
      `CHK("word1", w1, rv)
      rd(CWD_OFS_RESET_WORD, rv);
      `CHK("word2", w2, rv)
      do_reset();
      chk_opts();
      chk_clkpin();
      repeat (4) begin
        @(posedge clk_i);
        lvp_enable_i <= 1'($urandom);
        ctl(16'($urandom) & 16'h0038);
        chk_opts();
      end
      lock_test();
      stack_test();
      $display("test %0d done", t);
    end
    finish_test();
  end
endmodule // tb_cwd_decoder
